//--- rtl/cfg_reset_pkg.sv
// Package with types and constants for the configuration-done reset gating block
package cfg_reset_pkg;

    // Boot source select width and the code that names the JTAG scheme
    localparam int BOOT_SEL_W = 3;
    localparam logic [BOOT_SEL_W-1:0] BOOT_SEL_JTAG = 3'h7;

    // Reset values of the pin-facing outputs
    localparam logic RST_STATUS_N = 1'b0;
    localparam logic RST_INIT_DONE = 1'b0;
    localparam logic RST_USER_MODE_N = 1'b1;

    // Configuration manager states
    typedef enum logic [2:0] {
        ST_POR,
        ST_IDLE,
        ST_BOOT,
        ST_JTAG,
        ST_INIT,
        ST_USER
    } cfg_state_t;

    // Boot source that currently owns configuration
    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_BOOT_PINS,
        SRC_JTAG
    } cfg_source_t;

    // Events from the configuration engine
    typedef struct packed {
        logic por_done;
        logic load_done;
        logic load_error;
    } cfg_engine_t;

    // JTAG side request and the security lock on JTAG
    typedef struct packed {
        logic jtag_req;
        logic jtag_locked;
    } jtag_ctl_t;

    // Pin-facing outputs carried together
    typedef struct packed {
        logic config_status_n;
        logic init_done;
        logic core_user_mode_n;
    } cfg_pins_t;

endpackage

//--- rtl/config_done_reset_gating.sv
// Configuration manager end-of-configuration sequencer and reset-release source
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// [RULE_01] JTAG configuration wins over every other scheme, whatever the boot select says.
// [RULE_02] JTAG configuration is accepted at any time unless security locks JTAG; ignored in ST_POR, on ST_IDLE req_fall, at low request in ST_INIT/ST_USER.
// [RULE_03] Falling edge of config request aborts JTAG and returns to pin-selected boot.
// [RULE_04] Host keeps config request high and steady through a JTAG load.
// [RULE_05] During JTAG load the status output follows the config request level.
// [RULE_06] A JTAG load failure never pulls the status output low.
// [RULE_07] After power-on reset, low config request drives status low too.
// [RULE_08] Core user-mode flag is the inverse of external init-done, one behaviour.
// [RULE_09] User logic stays in reset while user-mode flag high or init-done low.
// [RULE_10] User-mode flag low only once every sector runs in user mode.
// [RULE_11] User logic may gate resets, PLL resets and write enables with the flag.
// [RULE_12] The core flag comes from one single sector manager, one copy only; here one register set from all sectors' reports, SRC_SECTOR unused.
// [RULE_13] PLL lock counts only together with the user-mode flag low.
// [RULE_14] The core flag is made whether or not init-done goes to a pin.
// [RULE_15] Without core flag, init-done leaves on a manager pin and comes back.
// [RULE_16] This gating covers full configurations only, not partial reconfiguration.
// [RULE_17] External init-done rises once the whole device is in user mode.
// [RULE_18] User logic synchronises the released reset into each clock domain.
module config_done_reset_gating
    import cfg_reset_pkg::*;
#(
    parameter int NUM_SECTORS = 4,
    parameter int SRC_SECTOR = 0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Configuration pins
    input wire logic config_request_n,
    input wire logic [BOOT_SEL_W-1:0] boot_mode_select,
    output logic config_status_n,
    output logic init_done,
    // Configuration engine and JTAG side
    input wire cfg_engine_t engine,
    input wire jtag_ctl_t jtag,
    // Sector managers report their sector in user mode
    input wire logic [NUM_SECTORS-1:0] sector_user_mode,
    // Core reset-release output and the selected source
    output logic core_user_mode_n,
    output cfg_source_t active_source,
    output logic jtag_error
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // True when all sectors have left the frozen state
    function automatic logic all_sectors_up(input logic [NUM_SECTORS-1:0] s);
        all_sectors_up = &s;
    endfunction

    // JTAG may take over only when security leaves it open
    function automatic logic jtag_allowed(input jtag_ctl_t j);
        jtag_allowed = j.jtag_req && !j.jtag_locked;
    endfunction

    // Source picked by the boot pins; the JTAG code means no automatic load
    function automatic cfg_source_t pin_source(input logic [BOOT_SEL_W-1:0] sel);
        if (sel == BOOT_SEL_JTAG) begin
            pin_source = SRC_NONE;
        end else begin
            pin_source = SRC_BOOT_PINS;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    // Control state and owning source
    cfg_state_t state;
    cfg_state_t next_state;
    cfg_source_t source;
    cfg_source_t next_source;

    // Sticky JTAG load failure
    logic err;
    logic next_err;

    // Pin-facing outputs, all registered
    cfg_pins_t pins;
    cfg_pins_t next_pins;

    // Request edge detector and sector samples
    logic req_prev;
    logic next_req_prev;
    logic [NUM_SECTORS-1:0] sector_q;
    logic [NUM_SECTORS-1:0] next_sector_q;

    // Decoded events shared between groups
    logic req_fall;
    logic jtag_go;
    logic jtag_start;
    logic boot_fail;

    ////////////////////////////////////////////////////////////////////////////
    // Input sampling

    // Previous request level; idles high like the pin, so no false edge after reset
    always_comb begin
        next_req_prev = config_request_n;
    end

    // Edge detector register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_prev <= 1'b1;
        end else begin
            req_prev <= next_req_prev;
        end
    end

    // One sample flop per sector manager report
    for (genvar g = 0; g < NUM_SECTORS; g++) begin : g_sector
        always_comb begin
            next_sector_q[g] = sector_user_mode[g];
        end
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                sector_q[g] <= 1'b0;
            end else begin
                sector_q[g] <= next_sector_q[g];
            end
        end
    end

    // Falling request edge and an open JTAG request
    assign req_fall = req_prev && !config_request_n;
    assign jtag_go = jtag_allowed(jtag);

    ////////////////////////////////////////////////////////////////////////////
    // Control next-state logic

    // State and owning source
    always_comb begin
        next_state = state;
        next_source = source;
        boot_fail = 1'b0;
        case (state)
            // Wait for power-on reset to finish
            ST_POR: begin
                if (engine.por_done) begin
                    next_state = ST_IDLE;
                end
            end

            // Idle: a request edge drops any JTAG ownership
            ST_IDLE: begin
                if (req_fall) begin // RULE_03
                    next_source = pin_source(boot_mode_select);
                end else if (jtag_go) begin // RULE_01
                    next_state = ST_JTAG; // RULE_02
                    next_source = SRC_JTAG;
                end else if (config_request_n) begin
                    next_state = ST_BOOT;
                    next_source = pin_source(boot_mode_select);
                end
            end

            // Pin-selected load; JTAG still wins
            ST_BOOT: begin
                if (jtag_go) begin // RULE_01
                    next_state = ST_JTAG;
                    next_source = SRC_JTAG;
                end else if (!config_request_n) begin
                    next_state = ST_IDLE;
                end else if (engine.load_error) begin
                    boot_fail = 1'b1;
                    next_state = ST_IDLE;
                end else if (engine.load_done && source == SRC_BOOT_PINS) begin
                    next_state = ST_INIT;
                end
            end

            // JTAG load; request edge aborts it
            ST_JTAG: begin
                if (req_fall) begin // RULE_03
                    next_state = ST_IDLE;
                    next_source = pin_source(boot_mode_select);
                end else if (engine.load_error) begin
                    next_state = ST_IDLE;
                end else if (engine.load_done) begin
                    next_state = ST_INIT;
                end
            end

            // Wait for every sector to run
            ST_INIT: begin
                if (!config_request_n) begin
                    next_state = ST_IDLE;
                    next_source = pin_source(boot_mode_select); // RULE_03
                end else if (jtag_go) begin // RULE_01
                    next_state = ST_JTAG; // RULE_02
                    next_source = SRC_JTAG;
                end else if (all_sectors_up(sector_q)) begin // RULE_10
                    next_state = ST_USER;
                end
            end

            // User mode until a new request or JTAG load
            ST_USER: begin
                if (!config_request_n) begin
                    next_state = ST_IDLE;
                    next_source = pin_source(boot_mode_select); // RULE_03
                end else if (jtag_go) begin // RULE_01
                    next_state = ST_JTAG; // RULE_02
                    next_source = SRC_JTAG;
                end
            end

            default: begin
                next_state = ST_POR;
            end
        endcase
    end

    // Control registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= ST_POR;
            source <= SRC_NONE;
        end else begin
            state <= next_state;
            source <= next_source;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // JTAG error flag

    // Entry into a JTAG load from any other state
    assign jtag_start = (next_state == ST_JTAG) && (state != ST_JTAG);

    // Set on a JTAG load failure, cleared at the next JTAG start
    always_comb begin
        next_err = err;
        if (state == ST_JTAG && !req_fall && engine.load_error) begin
            next_err = 1'b1; // RULE_06
        end else if (jtag_start) begin
            next_err = 1'b0;
        end
    end

    // Error register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            err <= 1'b0;
        end else begin
            err <= next_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin next-value logic

    // Status mirrors the request except in power-on and after a failed pin load
    always_comb begin
        next_pins = pins;
        if (state == ST_POR || boot_fail) begin
            next_pins.config_status_n = 1'b0;
        end else begin
            next_pins.config_status_n = config_request_n; // RULE_05 RULE_07
        end
        next_pins.init_done = (next_state == ST_USER); // RULE_17
        // Core flag is the inverse of init-done, made regardless of pin use
        next_pins.core_user_mode_n = !next_pins.init_done; // RULE_08 RULE_14
    end

    // Pin registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pins <= '{config_status_n: RST_STATUS_N, init_done: RST_INIT_DONE,
                      core_user_mode_n: RST_USER_MODE_N};
        end else begin
            pins <= next_pins;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, each from a flip-flop

    // Pin-facing levels
    assign config_status_n = pins.config_status_n;
    assign init_done = pins.init_done;

    // Single driver for the core flag, no copies to skew
    assign core_user_mode_n = pins.core_user_mode_n; // RULE_12

    // Status towards the JTAG side
    assign active_source = source;
    assign jtag_error = err;

endmodule

//--- verif/cfg_reset_assertions.sv
// Checker for the configuration-done reset gating block
`timescale 1ns/10ps
module cfg_reset_checker
    import cfg_reset_pkg::*;
#(parameter int NUM_SECTORS = 4) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Pins
    input wire logic config_request_n,
    input wire logic [BOOT_SEL_W-1:0] boot_mode_select,
    input wire logic config_status_n,
    input wire logic init_done,
    // Engine, JTAG and sectors
    input wire cfg_engine_t engine,
    input wire jtag_ctl_t jtag,
    input wire logic [NUM_SECTORS-1:0] sector_user_mode,
    // Results
    input wire logic core_user_mode_n,
    input wire cfg_source_t active_source,
    input wire logic jtag_error
);
    // All checks on the one clock, off during reset
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    chk_flag_inverse: assert property (core_user_mode_n == !init_done) else $error("flag not inverse");
    chk_done_all_sectors: assert property ($rose(init_done) |-> $past(&sector_user_mode, 2))
        else $error("done before all sectors");
    chk_status_follows: assert property (active_source == SRC_JTAG && $past(active_source) == SRC_JTAG
        |-> config_status_n == $past(config_request_n)) else $error("status not following");
    chk_low_req_status: assert property (!config_request_n && active_source != SRC_NONE
        |=> !config_status_n) else $error("status not low");
    chk_jtag_abort: assert property ($fell(config_request_n) && active_source == SRC_JTAG
        |=> active_source != SRC_JTAG) else $error("jtag not aborted");
    chk_err_no_status: assert property ($rose(jtag_error) && $past(config_request_n)
        |-> config_status_n) else $error("status low on jtag error");
    chk_jtag_locked: assert property (jtag.jtag_locked && active_source != SRC_JTAG
        |=> active_source != SRC_JTAG) else $error("locked jtag taken");
    chk_jtag_wins: assert property (jtag == 2'h2 && config_request_n && active_source == SRC_BOOT_PINS
        |=> active_source == SRC_JTAG) else $error("jtag not taken");
endmodule

bind config_done_reset_gating cfg_reset_checker #(.NUM_SECTORS(NUM_SECTORS)) i_cfg_reset_checker (.*);

//--- verif/user_reset_model.sv
// Model of user fabric logic holding itself in reset until the device is ready
`timescale 1ns/10ps
module user_reset_model (
    // Clock
    input wire logic clk_sys,
    // Device readiness
    input wire logic core_user_mode_n,
    input wire logic init_done,
    // Reset of the user logic
    output logic user_rst,
    // Reset of the user PLL
    output logic pll_rst
);
    logic [1:0] sync = 2'h3;
    // Held while flag high or init-done low, released through two flops
    always_ff @(posedge clk_sys) begin
        sync <= (core_user_mode_n || !init_done) ? 2'h3 : {sync[0], 1'b0};
    end
    assign user_rst = sync[1];
    // PLL held in reset by the flag; full configurations only, not partial
    always_ff @(posedge clk_sys) begin
        pll_rst <= core_user_mode_n;
    end
endmodule

//--- verif/config_done_reset_gating_tb.sv
// Testbench for the configuration-done reset gating block
`timescale 1ns/10ps
module config_done_reset_gating_tb;
    import cfg_reset_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, config_request_n = 1'b1, config_status_n, init_done, core_user_mode_n;
    logic jtag_error, user_rst, pll_rst;
    logic [BOOT_SEL_W-1:0] boot_mode_select = 3'h0;
    logic [3:0] sector_user_mode = 4'h0;
    cfg_engine_t engine = 3'h0;
    jtag_ctl_t jtag = 2'h0;
    cfg_source_t active_source;
    int miscompares = 0, n_compared = 0, i;
    initial forever #25 clk_sys = ~clk_sys;
    config_done_reset_gating #(.NUM_SECTORS(4), .SRC_SECTOR(0)) i_config_done_reset_gating (.clk_sys(clk_sys),
        .rst(rst), .config_request_n(config_request_n), .boot_mode_select(boot_mode_select),
        .config_status_n(config_status_n), .init_done(init_done), .engine(engine), .jtag(jtag),
        .sector_user_mode(sector_user_mode), .core_user_mode_n(core_user_mode_n),
        .active_source(active_source), .jtag_error(jtag_error));
    user_reset_model i_user_reset_model (.clk_sys(clk_sys), .core_user_mode_n(core_user_mode_n),
        .init_done(init_done), .user_rst(user_rst), .pll_rst(pll_rst));
    ////////////////////////////////////////
    // Source expected after a JTAG request
    function automatic logic [7:0] exp_src(input logic locked, input cfg_source_t cur);
        return locked ? 8'(cur) : 8'(SRC_JTAG);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence, inputs change on falling edges
    initial begin
        void'($urandom(32'h52a1702f));
        cyc(2);
        chk("status_n", 8'(RST_STATUS_N), config_status_n);
        chk("user_mode_n", 8'(RST_USER_MODE_N), core_user_mode_n);
        rst = 1'b0;
        engine.por_done = 1'b1;
        boot_mode_select = 3'($urandom_range(6));
        cyc(1);
        engine.por_done = 1'b0;
        cyc(3);
        chk("source", 8'(SRC_BOOT_PINS), active_source);
        for (i = 1; i >= 0; i--) begin
            jtag = {1'b1, i[0]};
            cyc(1);
            jtag = 2'h0;
            cyc(1);
            chk("source", exp_src(i[0], SRC_BOOT_PINS), active_source);
        end
        engine.load_error = 1'b1;
        cyc(1);
        engine.load_error = 1'b0;
        cyc(1);
        chk("jtag_error", 8'h01, jtag_error);
        chk("status_n", 8'h01, config_status_n);
        config_request_n = 1'b0;
        cyc(2);
        chk("status_n", 8'h00, config_status_n);
        chk("jtag held", 8'h00, 8'(active_source == SRC_JTAG));
        config_request_n = 1'b1;
        cyc(3);
        jtag = 2'h2;
        cyc(1);
        jtag = 2'h0;
        chk("status_n", 8'h01, config_status_n);
        engine.load_done = 1'b1;
        cyc(1);
        engine.load_done = 1'b0;
        sector_user_mode = 4'($urandom_range(14));
        cyc(6);
        chk("init_done", 8'h00, init_done);
        chk("user_rst", 8'h01, user_rst);
        chk("pll_rst", 8'h01, pll_rst);
        sector_user_mode = 4'hf;
        for (i = 0; i < 20 && init_done !== 1'b1; i++) cyc(1);
        chk("init_done", 8'h01, init_done);
        chk("user_mode_n", 8'h00, core_user_mode_n);
        cyc(3);
        chk("user_rst", 8'h00, user_rst);
        chk("pll_rst", 8'h00, pll_rst);
        stop_test();
    end
endmodule
